// File: hdl/pwc_periodic_wakeup_counter.sv
// Periodic wakeup counter: source select, prescaler, 8-bit counter with match limit and flag.
//
// Overview of operation
// - Eight-bit up-counter, eight-bit match limit, source selector and binary/decimal prescaler.
// - Reset stops and clears the counter, clears the match limit, prescaler off.
// - After reset the 1 kHz low-power oscillator is the counting source.
// - Prescaler off while prescale select is zero; any nonzero value starts it.
// - Writing a different source select clears prescaler and counter.
// - Writing a different prescale select clears prescaler and counter.
// - Divide ratio depends on prescale select and source select low bit.
// - Low-power source, code 0001 divides by eight.
// - Low-power source, code 1000 divides by one.
// - Low-power source, code 0xA divides by four.
// - Match limit accepts any value from zero to all ones.
// - Counter steps once per prescaler period up to the limit, then wraps.
// - Match flag sets when the counter steps from the limit to zero.
// - Any write to the match limit clears prescaler and counter.
// - Interrupt request is flag and enable together; no request without enable.
// - Writing one to the flag bit clears the match flag.
// - Source code 00 low-power, 01 external, 1x internal reference.
// - Full binary and decimal divide tables for both values of select bit zero.
// - With limit zero the flag sets on every prescaler output edge.
// - Writing zero to the flag has no effect; reset clears flag and control fields.
`timescale 1ns/1ps
module pwc_periodic_wakeup_counter
   import pwc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_low_power_osc_clock,
   input wire logic i_external_ref_clock,
   input wire logic i_internal_ref_clock,
   input wire logic i_status_control_write,
   input wire logic [7:0] i_status_control_wdata,
   input wire logic i_match_limit_write,
   input wire logic [7:0] i_match_limit_wdata,
   output logic [7:0] o_status_control,
   output logic o_match_flag,
   output logic o_match_irq_enable,
   output logic [1:0] o_clock_source_select,
   output logic [3:0] o_prescale_select,
   output logic [7:0] o_count_value,
   output logic [7:0] o_match_limit,
   output logic o_irq
);

   typedef struct packed {
      logic [PWC_PRESC_W-1:0] presc;
      logic [PWC_CNT_W-1:0] count;
      logic [PWC_CNT_W-1:0] limit;
      logic flag;
      logic irq_en;
      logic [1:0] clks;
      logic [3:0] ps;
      logic irq;
      logic [7:0] sc_read;
   } pwc_state_t;

   pwc_state_t st_q;
   pwc_state_t st_d;
   logic [PWC_NUM_SRC-1:0] src_rise;
   logic src_edge;
   logic [PWC_PRESC_W-1:0] divisor;
   logic [1:0] wr_clks;
   logic [3:0] wr_ps;
   logic cfg_change;
   logic step;

   // Each source pin is foreign to i_clock, so all of them are sampled through three stages.
   pwc_edge_sync #(
      .WIDTH(PWC_NUM_SRC)
   ) u_sync (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_async({i_internal_ref_clock, i_external_ref_clock, i_low_power_osc_clock}),
      .o_rise(src_rise)
   );

   // Source select; each source level must be seen on two i_clock edges, so sources must stay below a quarter of the i_clock rate.
   always_comb begin
      case (st_q.clks)
         PWC_SRC_LPO: src_edge = src_rise[PWC_IDX_LPO];
         PWC_SRC_EXT: src_edge = src_rise[PWC_IDX_EXT];
         default: src_edge = src_rise[PWC_IDX_INT];
      endcase
   end

   // Divide ratio from the table; zero means the prescaler is off.
   assign divisor = pwc_divisor(st_q.ps, st_q.clks[0]);

   // Write decode of the control fields.
   assign wr_clks = i_status_control_wdata[PWC_CLKS_HI:PWC_CLKS_LO];
   assign wr_ps = i_status_control_wdata[PWC_PS_HI:PWC_PS_LO];
   assign cfg_change = i_status_control_write && ((wr_clks != st_q.clks) || (wr_ps != st_q.ps));

   // One prescaler output period has ended when the last source edge of the ratio arrives.
   assign step = (st_q.ps != PWC_PS_OFF) && src_edge && (st_q.presc == divisor - 18'h00001);

   // Next state. A clearing write beats a step in the same cycle, but a flag set beats a clear.
   always_comb begin
      st_d = st_q;
      if (st_q.ps == PWC_PS_OFF) begin
         st_d.presc = PWC_PRESC_RST;
      end else if (step) begin
         st_d.presc = PWC_PRESC_RST;
      end else if (src_edge) begin
         st_d.presc = st_q.presc + 18'h00001;
      end
      if (step) begin
         if (st_q.count == st_q.limit) begin
            st_d.count = PWC_CNT_RST;
         end else begin
            st_d.count = st_q.count + 8'h01;
         end
      end
      // Flag: software clear by a one, then hardware set has the last word.
      if (i_status_control_write && i_status_control_wdata[PWC_FLAG_BIT]) begin
         st_d.flag = 1'b0;
      end
      if (step && (st_q.count == st_q.limit)) begin
         st_d.flag = 1'b1;
      end
      if (i_status_control_write) begin
         st_d.clks = wr_clks;
         st_d.ps = wr_ps;
         st_d.irq_en = i_status_control_wdata[PWC_IE_BIT];
      end
      if (cfg_change) begin
         st_d.presc = PWC_PRESC_RST;
         st_d.count = PWC_CNT_RST;
      end
      if (i_match_limit_write) begin
         st_d.limit = i_match_limit_wdata;
         st_d.presc = PWC_PRESC_RST;
         st_d.count = PWC_CNT_RST;
      end
      st_d.irq = st_d.flag && st_d.irq_en;
      st_d.sc_read = {st_d.flag, st_d.clks, st_d.irq_en, st_d.ps};
   end

   // State register; reset leaves the counter stopped and every field cleared.
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         st_q.presc <= PWC_PRESC_RST;
         st_q.count <= PWC_CNT_RST;
         st_q.limit <= PWC_MOD_RST;
         st_q.flag <= 1'b0;
         st_q.irq_en <= 1'b0;
         st_q.clks <= PWC_CLKS_RST;
         st_q.ps <= PWC_PS_RST;
         st_q.irq <= 1'b0;
         st_q.sc_read <= 8'h00;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register; the count has no write path at all.
   assign o_count_value = st_q.count;
   assign o_status_control = st_q.sc_read;
   assign o_match_flag = st_q.flag;
   assign o_match_irq_enable = st_q.irq_en;
   assign o_clock_source_select = st_q.clks;
   assign o_prescale_select = st_q.ps;
   assign o_match_limit = st_q.limit;
   assign o_irq = st_q.irq;

endmodule

// File: hdl/pwc_pkg.sv
// Package with the field layout, reset values and divide table of the wakeup counter.
package pwc_pkg;

   // Widths of the counting parts.
   localparam int PWC_CNT_W = 8;
   localparam int PWC_PRESC_W = 18;
   localparam int PWC_NUM_SRC = 3;

   // Field positions inside the status and control byte.
   localparam int PWC_FLAG_BIT = 7;
   localparam int PWC_CLKS_HI = 6;
   localparam int PWC_CLKS_LO = 5;
   localparam int PWC_IE_BIT = 4;
   localparam int PWC_PS_HI = 3;
   localparam int PWC_PS_LO = 0;

   // Clock source select codes; any code with the high bit set picks the internal reference.
   localparam logic [1:0] PWC_SRC_LPO = 2'h0;
   localparam logic [1:0] PWC_SRC_EXT = 2'h1;

   // Indices of the source clocks in the sampled source vector.
   localparam int PWC_IDX_LPO = 0;
   localparam int PWC_IDX_EXT = 1;
   localparam int PWC_IDX_INT = 2;

   // Reset values.
   localparam logic [1:0] PWC_CLKS_RST = 2'h0;
   localparam logic [3:0] PWC_PS_RST = 4'h0;
   localparam logic [7:0] PWC_CNT_RST = 8'h00;
   localparam logic [7:0] PWC_MOD_RST = 8'h00;
   localparam logic [17:0] PWC_PRESC_RST = 18'h00000;
   localparam logic [3:0] PWC_PS_OFF = 4'h0;

   // Divide ratio for a prescale code and the low bit of the source select; zero means off.
   function automatic logic [17:0] pwc_divisor(input logic [3:0] ps, input logic sel0);
      logic [17:0] r;
      r = 18'h00000;
      if (!sel0) begin
         case (ps)
            4'h1: r = 18'h00008;
            4'h2: r = 18'h00020;
            4'h3: r = 18'h00040;
            4'h4: r = 18'h00080;
            4'h5: r = 18'h00100;
            4'h6: r = 18'h00200;
            4'h7: r = 18'h00400;
            4'h8: r = 18'h00001;
            4'h9: r = 18'h00002;
            4'ha: r = 18'h00004;
            4'hb: r = 18'h0000a;
            4'hc: r = 18'h00010;
            4'hd: r = 18'h00064;
            4'he: r = 18'h001f4;
            4'hf: r = 18'h003e8;
            default: r = 18'h00000;
         endcase
      end else begin
         case (ps)
            4'h1: r = 18'h00400;
            4'h2: r = 18'h00800;
            4'h3: r = 18'h01000;
            4'h4: r = 18'h02000;
            4'h5: r = 18'h04000;
            4'h6: r = 18'h08000;
            4'h7: r = 18'h10000;
            4'h8: r = 18'h003e8;
            4'h9: r = 18'h007d0;
            4'ha: r = 18'h01388;
            4'hb: r = 18'h02710;
            4'hc: r = 18'h04e20;
            4'hd: r = 18'h0c350;
            4'he: r = 18'h186a0;
            4'hf: r = 18'h30d40;
            default: r = 18'h00000;
         endcase
      end
      return r;
   endfunction

endpackage

// File: hdl/pwc_edge_sync.sv
// Three-stage synchroniser with rising edge detection for the source clock pins.
`timescale 1ns/1ps
module pwc_edge_sync #(
   parameter int WIDTH = 3
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_rise
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
      logic [WIDTH-1:0] rise;
   } pwc_sync_t;

   pwc_sync_t st_q;
   pwc_sync_t st_d;

   // A new level is accepted only once the second and third stages agree, so a glitch or a
   // metastable first stage never produces an edge; this costs one extra cycle of latency.
   always_comb begin
      st_d = st_q;
      st_d.s1 = i_async;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.lvl = (st_q.s2 & ~(st_q.s2 ^ st_q.s3)) | (st_q.lvl & (st_q.s2 ^ st_q.s3));
      st_d.rise = st_d.lvl & ~st_q.lvl;
   end

   // State register with synchronous reset.
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_rise = st_q.rise;

endmodule

// File: testbench/pwc_wakeup_asserts.sv
// Port-level checks of the periodic wakeup counter.
`timescale 1ns/1ps
module pwc_wakeup_asserts (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_status_control_write,
   input wire logic [7:0] i_status_control_wdata,
   input wire logic i_match_limit_write,
   input wire logic [7:0] i_match_limit_wdata,
   input wire logic o_match_flag,
   input wire logic o_match_irq_enable,
   input wire logic [1:0] o_clock_source_select,
   input wire logic [3:0] o_prescale_select,
   input wire logic [7:0] o_count_value,
   input wire logic [7:0] o_match_limit,
   input wire logic o_irq
);
   logic sw;
   logic [7:0] wd;
   logic [7:0] cnt;
   // Short aliases keep all but two properties on one readable line.
   assign sw = i_status_control_write;
   assign wd = i_status_control_wdata;
   assign cnt = o_count_value;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // A wrap leaves the limit for zero; a limit write also zeroes the count, so both are compared.
   sequence s_wrap;
      cnt == 8'h00 && $past(cnt) == $past(o_match_limit);
   endsequence
   AST_IRQ: assert property (o_irq == (o_match_flag && o_match_irq_enable))
      else $error("irq differs from flag and enable");
   AST_FSET: assert property ($rose(o_match_flag) |-> s_wrap)
      else $error("flag set without a wrap");
   AST_FKEEP: assert property (sw && !wd[7] && o_match_flag |=> o_match_flag)
      else $error("flag lost on a zero write");
   AST_LIM: assert property (i_match_limit_write |=> cnt == 8'h00 &&
      o_match_limit == $past(i_match_limit_wdata)) else $error("limit write wrong");
   AST_CLKS: assert property (sw && wd[6:5] != o_clock_source_select |=> cnt == 8'h00)
      else $error("source change kept count");
   AST_PSCL: assert property (sw && wd[3:0] != o_prescale_select |=> cnt == 8'h00)
      else $error("prescale change kept count");
   AST_OFF: assert property (o_prescale_select == 4'h0 |-> cnt == 8'h00)
      else $error("count moved while off");
   AST_STEP: assert property ($changed(cnt) |-> cnt == 8'h00 || cnt == $past(cnt) + 8'h01)
      else $error("count skipped");
   AST_FLD: assert property (sw |=> o_prescale_select == $past(wd[3:0]) &&
      o_clock_source_select == $past(wd[6:5])) else $error("fields not stored");
endmodule
bind pwc_periodic_wakeup_counter pwc_wakeup_asserts u_pwc_wakeup_asserts (.*);

// File: testbench/pwc_periodic_wakeup_counter_bench.sv
// Self-checking bench of the periodic wakeup counter.
`timescale 1ns/1ps
module pwc_periodic_wakeup_counter_bench;
   logic i_clock;
   logic i_rst_n = 1'b0;
   logic i_status_control_write = 1'b0;
   logic i_match_limit_write = 1'b0;
   logic [7:0] i_status_control_wdata = 8'h00;
   logic [7:0] i_match_limit_wdata = 8'h00;
   logic [2:0] src = 3'h0;
   logic [7:0] o_status_control, o_count_value, o_match_limit;
   logic o_match_flag, o_match_irq_enable, o_irq;
   logic [1:0] o_clock_source_select;
   logic [3:0] o_prescale_select;
   int fail_count = 0;
   int checks = 0;
   logic [7:0] code [4] = '{8'h08, 8'h09, 8'h0a, 8'h01};
   logic [7:0] steps [4] = '{8'h08, 8'h04, 8'h02, 8'h01};
   pwc_periodic_wakeup_counter u_pwc_periodic_wakeup_counter (.*,
      .i_low_power_osc_clock(src[0]), .i_external_ref_clock(src[1]),
      .i_internal_ref_clock(src[2]));
   // Free-running 100 MHz clock.
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   // One write; the extra edge lets the outputs settle before anyone samples them.
   task automatic wr(input logic lim, input logic [7:0] v);
      @(posedge i_clock);
      if (lim) begin
         i_match_limit_write <= 1'b1;
         i_match_limit_wdata <= v;
      end else begin
         i_status_control_write <= 1'b1;
         i_status_control_wdata <= v;
      end
      @(posedge i_clock);
      i_match_limit_write <= 1'b0;
      i_status_control_write <= 1'b0;
      @(posedge i_clock);
   endtask
   // Source pulses last three cycles each way so the synchroniser never misses one.
   task automatic pul(input int i, input int n);
      repeat (n) begin
         @(posedge i_clock);
         src[i] <= 1'b1;
         repeat (3) @(posedge i_clock);
         src[i] <= 1'b0;
         repeat (2) @(posedge i_clock);
      end
      repeat (6) @(posedge i_clock);
   endtask
   task automatic print_verdict();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Main sequence of tests.
   initial begin
      repeat (20) @(posedge i_clock);
      i_rst_n <= 1'b1;
      @(posedge i_clock);
      chk(o_status_control, 8'h00);
      chk(o_match_limit, 8'h00);
      pul(0, 2);
      chk(o_count_value, 8'h00);
      $display("reset test done");
      wr(1'b1, 8'hff);
      for (int k = 0; k < 4; k++) begin
         wr(1'b0, code[k]);
         pul(0, 8);
         chk(o_count_value, steps[k]);
      end
      $display("divide test done");
      wr(1'b1, 8'h02);
      wr(1'b0, 8'h18);
      pul(0, 3);
      chk(o_status_control, 8'h98);
      chk({7'h00, o_irq}, 8'h01);
      wr(1'b0, 8'h18);
      chk(o_status_control, 8'h98);
      wr(1'b0, 8'h98);
      chk(o_status_control, 8'h18);
      pul(0, 1);
      chk(o_count_value, 8'h01);
      $display("flag test done");
      wr(1'b0, 8'h19);
      chk(o_count_value, 8'h00);
      pul(0, 2);
      wr(1'b1, 8'h05);
      chk(o_count_value, 8'h00);
      pul(0, 2);
      wr(1'b0, 8'h59);
      chk(o_count_value, 8'h00);
      pul(0, 2);
      pul(2, 2);
      chk(o_count_value, 8'h01);
      wr(1'b0, 8'h28);
      pul(1, 2);
      chk(o_count_value, 8'h00);
      wr(1'b0, 8'h48);
      wr(1'b1, 8'h00);
      pul(2, 1);
      chk(o_status_control, 8'hc8);
      chk({7'h00, o_irq}, 8'h00);
      wr(1'b0, 8'h80);
      chk(o_status_control, 8'h00);
      $display("clear test done");
      print_verdict();
   end
   // The tests need well under two thousand cycles, so this bound only trips on a hang.
   initial begin
      repeat (20000) @(posedge i_clock);
      fail_count++;
      print_verdict();
   end
endmodule
